//--- hdl/clock_fanout_pkg.sv
// Purpose: Shared constants and types for the clock fan-out model
// Assumes: One sampling clock at 10 MHz; reference far slower than it
// Notes: Times are given in their own unit and converted to cycles here
package clock_fanout_pkg;
    localparam int CLK_FREQ_KHZ = 10000;
    localparam int LOCK_TIME_US = 1000;
    // Longest time rounds down
    localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_FREQ_KHZ / 1000;
    localparam int BANK_A_WIDTH = 5;
    localparam int BANK_B_WIDTH = 4;
    localparam int PIN_COUNT = 5;
    localparam int PER_WIDTH = 8;
    localparam int LOCK_WIDTH = 16;
    // Reference treated as stopped once a period reaches this count
    localparam logic [PER_WIDTH-1:0] PER_STALL = 8'hFF;
    // Feedback edge may trail the reference edge by this many cycles
    // Output flop and feedback synchroniser delay the return by five
    localparam logic [PER_WIDTH-1:0] FB_WINDOW = 8'h06;
    localparam logic [PER_WIDTH-1:0] PER_RESET = 8'h00;
    localparam logic [LOCK_WIDTH-1:0] LOCK_RESET = 16'h0000;
    localparam logic [PIN_COUNT-1:0] PIN_RESET = 5'h00;
    // Pin positions in the synchroniser vector
    localparam int PIN_REF = 0;
    localparam int PIN_FB = 1;
    localparam int PIN_EN_A = 2;
    localparam int PIN_EN_B = 3;
    localparam int PIN_STRAP = 4;

    typedef struct packed {
        logic [BANK_A_WIDTH-1:0] bank_a;
        logic [BANK_B_WIDTH-1:0] bank_b;
        logic feedback;
    } clock_outputs_type;

    typedef enum logic [0:0] {
        ACQUIRE,
        LOCKED
    } lock_state_type;
endpackage

//--- hdl/clock_fanout.sv
// Purpose: Behavioural fan-out driver with loop lock and bypass strap
// Assumes: Reference, feedback, enables and strap are asynchronous pins
// Notes: Outputs are rebuilt on CLK, so edges carry CLK-period jitter
//
// What this block does
// - Two banks, five and four outputs, nine reference copies in all.
// - Bank A enable low holds its five outputs low; high lets them toggle.
// - Bank B enable low holds its four outputs low; high lets them toggle.
// - Enabled outputs match reference phase and rate; enables act alone.
// - Outside bypass, all outputs run high for half the period, rounded down, whatever the reference duty.
// - Feedback toggles whatever the enables; outside bypass, low while reference stopped.
// - Once locked, feedback rising edges land within six cycles after reference rising edges.
// - Alignment only after settling, which restarts on power-up or change.
// - Strap low bypasses the loop and buffers reference straight through.
// - Settling lasts at least one millisecond; timing undefined before lock.
`timescale 1ns/1ps
module clock_fanout
    import clock_fanout_pkg::*;
#(
    parameter int LOCK_COUNT = LOCK_CYCLES
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic REF_CLK_IN,
    input wire logic LOOP_FEEDBACK_IN,
    input wire logic BANK_A_ENABLE,
    input wire logic BANK_B_ENABLE,
    input wire logic ANALOG_SUPPLY_BYPASS_STRAP,
    output logic [BANK_A_WIDTH-1:0] BANK_A_CLOCK_OUT,
    output logic [BANK_B_WIDTH-1:0] BANK_B_CLOCK_OUT,
    output logic LOOP_FEEDBACK_OUT,
    output logic LOCK_FLAG
);
    logic rst_meta_q;
    logic rst_n_q;
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_s1_q;
    logic [PIN_COUNT-1:0] pin_s2_q;
    logic [PIN_COUNT-1:0] pin_s3_q;
    logic [PIN_COUNT-1:0] pin_q;
    logic ref_prev_q;
    logic fb_prev_q;
    logic [PER_WIDTH-1:0] cnt_q;
    logic [PER_WIDTH-1:0] cnt_d;
    logic [PER_WIDTH-1:0] per_q;
    logic [PER_WIDTH-1:0] phase_q;
    logic [PER_WIDTH-1:0] phase_d;
    logic fb_seen_q;
    logic [LOCK_WIDTH-1:0] lock_cnt_q;
    lock_state_type state_q;
    lock_state_type state_d;
    clock_outputs_type out_q;
    clock_outputs_type out_d;

    // Reset released through two flops so every flop leaves reset together
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    assign pin_raw[PIN_REF] = REF_CLK_IN;
    assign pin_raw[PIN_FB] = LOOP_FEEDBACK_IN;
    assign pin_raw[PIN_EN_A] = BANK_A_ENABLE;
    assign pin_raw[PIN_EN_B] = BANK_B_ENABLE;
    assign pin_raw[PIN_STRAP] = ANALOG_SUPPLY_BYPASS_STRAP;

    // Four flops per pin; a change is taken once stages two and three agree
    // Strap clears to bypass, harmless as the reference copy clears low
    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++) begin : g_pin
            always_ff @(posedge CLK or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    pin_s1_q[g] <= PIN_RESET[g];
                    pin_s2_q[g] <= PIN_RESET[g];
                    pin_s3_q[g] <= PIN_RESET[g];
                    pin_q[g] <= PIN_RESET[g];
                end else begin
                    pin_s1_q[g] <= pin_raw[g];
                    pin_s2_q[g] <= pin_s1_q[g];
                    pin_s3_q[g] <= pin_s2_q[g];
                    if (pin_s2_q[g] == pin_s3_q[g]) begin
                        pin_q[g] <= pin_s3_q[g];
                    end
                end
            end
        end
    endgenerate

    // One edge test serves the reference and the returning feedback
    function automatic logic rising(input logic now_lvl, input logic old_lvl);
        return now_lvl && !old_lvl;
    endfunction

    wire ref_level = pin_q[PIN_REF];
    wire ref_rise = rising(ref_level, ref_prev_q);
    wire fb_rise = rising(pin_q[PIN_FB], fb_prev_q);
    wire bypass = !pin_q[PIN_STRAP];
    // A stopped reference must not leave the banks frozen high
    wire stalled = (cnt_q == PER_STALL);
    wire [PER_WIDTH-1:0] new_per = cnt_q + 8'h01;
    wire per_change = ref_rise && (new_per != per_q);
    // Feedback must land just after the reference edge, once per period
    wire fb_late = fb_rise && (phase_q > FB_WINDOW);
    wire fb_missing = ref_rise && !fb_seen_q;
    wire disturb = per_change || stalled || fb_late || fb_missing;
    // Half of the measured period gives the even duty regardless of input
    wire gen_high = (phase_q < {1'b0, per_q[PER_WIDTH-1:1]});
    wire gen_clk = bypass ? ref_level : (gen_high && !stalled);

    assign cnt_d = ref_rise ? PER_RESET : (stalled ? cnt_q : cnt_q + 8'h01);
    // Generator phase restarts on each reference edge to hold alignment
    assign phase_d = ref_rise ? PER_RESET
                   : (phase_q == PER_STALL ? phase_q : phase_q + 8'h01);

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ref_prev_q <= 1'b0;
            fb_prev_q <= 1'b0;
        end else begin
            ref_prev_q <= ref_level;
            fb_prev_q <= pin_q[PIN_FB];
        end
    end

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cnt_q <= PER_RESET;
            per_q <= PER_RESET;
            phase_q <= PER_RESET;
        end else begin
            cnt_q <= cnt_d;
            phase_q <= phase_d;
            if (ref_rise) begin
                per_q <= new_per;
            end
        end
    end

    // A period with no returning edge means the board loop is open
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            fb_seen_q <= 1'b0;
        end else if (ref_rise) begin
            fb_seen_q <= fb_rise;
        end else if (fb_rise) begin
            fb_seen_q <= 1'b1;
        end
    end

    // Lock needs a steady period and a returning feedback edge
    always_comb begin
        state_d = state_q;
        case (state_q)
            ACQUIRE: begin
                if (!disturb && lock_cnt_q >= LOCK_COUNT[LOCK_WIDTH-1:0]) begin
                    state_d = LOCKED;
                end
            end
            LOCKED: begin
                if (disturb) begin
                    state_d = ACQUIRE;
                end
            end
            default: state_d = ACQUIRE;
        endcase
    end

    // Flag drops on the edge after any disturbance
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= ACQUIRE;
        end else begin
            state_q <= state_d;
        end
    end

    // Counter saturates so a long lock never wraps into a false restart
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lock_cnt_q <= LOCK_RESET;
        end else if (disturb) begin
            lock_cnt_q <= LOCK_RESET;
        end else if (lock_cnt_q != {LOCK_WIDTH{1'b1}}) begin
            lock_cnt_q <= lock_cnt_q + 16'h0001;
        end
    end

    // Banks gate the shared clock; feedback ignores both enables
    // Every pin of a bank takes the same gate term, so a bank never splits
    generate
        for (g = 0; g < BANK_A_WIDTH; g++) begin : g_bank_a
            assign out_d.bank_a[g] = gen_clk && pin_q[PIN_EN_A];
        end
        for (g = 0; g < BANK_B_WIDTH; g++) begin : g_bank_b
            assign out_d.bank_b[g] = gen_clk && pin_q[PIN_EN_B];
        end
    endgenerate
    assign out_d.feedback = gen_clk;

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            out_q <= '0;
        end else begin
            out_q <= out_d;
        end
    end

    assign BANK_A_CLOCK_OUT = out_q.bank_a;
    assign BANK_B_CLOCK_OUT = out_q.bank_b;
    assign LOOP_FEEDBACK_OUT = out_q.feedback;
    assign LOCK_FLAG = (state_q == LOCKED);
endmodule

//--- tb/clock_fanout_sva.sv
// Purpose: Port checks for the clock fan-out model
// Assumes: Pin changes reach outputs five edges later
// Notes: Enable windows of six samples cover that latency
`timescale 1ns/1ps
module clock_fanout_sva
    import clock_fanout_pkg::*;
#(
    parameter int LOCK_COUNT = 20
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic REF_CLK_IN,
    input wire logic BANK_A_ENABLE,
    input wire logic BANK_B_ENABLE,
    input wire logic ANALOG_SUPPLY_BYPASS_STRAP,
    input wire logic [BANK_A_WIDTH-1:0] BANK_A_CLOCK_OUT,
    input wire logic [BANK_B_WIDTH-1:0] BANK_B_CLOCK_OUT,
    input wire logic LOOP_FEEDBACK_OUT,
    input wire logic LOCK_FLAG
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    logic [15:0] up_q;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) up_q <= 16'h0000;
        else if (up_q != 16'hFFFF) up_q <= up_q + 16'h0001;
    end
    // Cycles since the reference pin was last seen high
    logic [8:0] idle_q;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) idle_q <= 9'h000;
        else if (REF_CLK_IN) idle_q <= 9'h000;
        else if (idle_q != 9'h1FF) idle_q <= idle_q + 9'h001;
    end
    sequence strap_low;
        !ANALOG_SUPPLY_BYPASS_STRAP [*7];
    endsequence
    sequence bank_a_on;
        BANK_A_ENABLE [*6];
    endsequence
    sequence bank_b_on;
        BANK_B_ENABLE [*6];
    endsequence
    sequence bank_a_off;
        !BANK_A_ENABLE [*6];
    endsequence
    sequence bank_b_off;
        !BANK_B_ENABLE [*6];
    endsequence
    a_bank_a_even: assert property (
        &BANK_A_CLOCK_OUT || ~|BANK_A_CLOCK_OUT)
        else $error("bank A bits differ");
    a_bank_b_even: assert property (
        &BANK_B_CLOCK_OUT || ~|BANK_B_CLOCK_OUT)
        else $error("bank B bits differ");
    a_bank_a_off: assert property (bank_a_off |-> ~|BANK_A_CLOCK_OUT)
        else $error("bank A not held low");
    a_bank_b_off: assert property (bank_b_off |-> ~|BANK_B_CLOCK_OUT)
        else $error("bank B not held low");
    a_bank_a_follow: assert property (
        bank_a_on |-> BANK_A_CLOCK_OUT[0] == LOOP_FEEDBACK_OUT)
        else $error("bank A off feedback");
    a_bank_b_follow: assert property (
        bank_b_on |-> BANK_B_CLOCK_OUT[0] == LOOP_FEEDBACK_OUT)
        else $error("bank B off feedback");
    a_bypass_pass: assert property (
        strap_low |-> LOOP_FEEDBACK_OUT == $past(REF_CLK_IN, 5))
        else $error("bypass not passing reference");
    a_lock_settle: assert property (
        $rose(LOCK_FLAG) |-> up_q > 16'(LOCK_COUNT))
        else $error("lock before settling time");
    a_stop_quiet: assert property (
        idle_q > {1'b0, PER_STALL} + 9'h010 |-> !LOCK_FLAG && !LOOP_FEEDBACK_OUT)
        else $error("outputs alive with reference stopped");
endmodule
bind clock_fanout clock_fanout_sva #(.LOCK_COUNT(LOCK_COUNT)) u_sva (
    .CLK(CLK), .RSTN(RSTN), .REF_CLK_IN(REF_CLK_IN),
    .BANK_A_ENABLE(BANK_A_ENABLE), .BANK_B_ENABLE(BANK_B_ENABLE),
    .ANALOG_SUPPLY_BYPASS_STRAP(ANALOG_SUPPLY_BYPASS_STRAP),
    .BANK_A_CLOCK_OUT(BANK_A_CLOCK_OUT), .BANK_B_CLOCK_OUT(BANK_B_CLOCK_OUT),
    .LOOP_FEEDBACK_OUT(LOOP_FEEDBACK_OUT), .LOCK_FLAG(LOCK_FLAG));

//--- tb/ref_source.sv
// Purpose: Reference clock source for the fan-out model
// Assumes: Period and high time counted in CLK cycles
// Notes: Rests low while stopped, as a halted source would
`timescale 1ns/1ps
module ref_source (
    input wire logic clk,
    input wire logic run,
    input int period,
    input int high_time,
    output logic ref_out
);
    int cnt = 0;
    initial ref_out = 1'b0;
    always @(posedge clk) begin
        cnt <= (!run || cnt >= period - 1) ? 0 : cnt + 1;
        ref_out <= #1 run && (cnt < high_time);
    end
endmodule

//--- tb/pll_clock_fanout_banks_bench.sv
// Purpose: Self-checking bench for the clock fan-out model
// Assumes: Feedback output wired straight to feedback input
// Notes: Lock count shortened so settling stays brief
`timescale 1ns/1ps
module pll_clock_fanout_banks_bench;
    import clock_fanout_pkg::*;
    localparam int LOCK_SIM = 20;
    logic CLK = 1'b0, RSTN = 1'b0, run = 1'b0, ref_clk, lock;
    logic en_a = 1'b1, en_b = 1'b1, strap = 1'b1;
    logic [BANK_A_WIDTH-1:0] out_a;
    logic [BANK_B_WIDTH-1:0] out_b;
    wire fb;
    int period = 10, high_time = 5, failures = 0, checks_done = 0, cyc_n = 0;
    always #50 CLK = ~CLK;
    ref_source u_ref_source (.clk(CLK), .run(run), .period(period),
        .high_time(high_time), .ref_out(ref_clk));
    clock_fanout #(.LOCK_COUNT(LOCK_SIM)) u_clock_fanout (.CLK(CLK),
        .RSTN(RSTN), .REF_CLK_IN(ref_clk), .LOOP_FEEDBACK_IN(fb),
        .BANK_A_ENABLE(en_a), .BANK_B_ENABLE(en_b),
        .ANALOG_SUPPLY_BYPASS_STRAP(strap), .BANK_A_CLOCK_OUT(out_a),
        .BANK_B_CLOCK_OUT(out_b), .LOOP_FEEDBACK_OUT(fb), .LOCK_FLAG(lock));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic measure(output logic [15:0] hi, output logic [15:0] lo);
        hi = 16'h0000;
        lo = 16'h0000;
        while (fb !== 1'b0) cyc(1);
        while (fb !== 1'b1) cyc(1);
        while (fb === 1'b1) begin
            hi++;
            cyc(1);
        end
        while (fb === 1'b0) begin
            lo++;
            cyc(1);
        end
    endtask
    function automatic logic [15:0] half(input int p);
        return 16'(p / 2);
    endfunction
    always @(posedge CLK) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            failures++;
            $display("MISMATCH at %0t: run timed out", $time);
            wrap_up();
        end
    end
    initial begin
        logic [15:0] hi, lo;
        logic [2:0] any;
        void'($urandom(77));
        cyc(5);
        RSTN = 1'b1;
        run = 1'b1;
        // First period odd; duty swung between the 40 and 60 percent ends
        for (int i = 0; i < 4; i++) begin
            period = (i == 0) ? 9 : 8 + $urandom % 13;
            high_time = ($urandom % 2) ? (2 * period + 4) / 5 : 3 * period / 5;
            cyc(LOCK_SIM + 6 * period);
            measure(hi, lo);
            check(hi, half(period));
            check(hi + lo, 16'(period));
            check(16'(lock), 16'h0001);
            $display("normal period %0d done", period);
        end
        for (int m = 0; m < 4; m++) begin
            {en_a, en_b} = 2'(m);
            cyc(8);
            any = 3'b000;
            repeat (2 * period) begin
                any |= {|out_a, |out_b, fb};
                cyc(1);
            end
            check(16'(any), {13'h0000, en_a, en_b, 1'b1});
            $display("enable pair %0d done", m);
        end
        period = 10;
        high_time = 4;
        strap = 1'b0;
        cyc(30);
        measure(hi, lo);
        check(hi, 16'h0004);
        $display("bypass done");
        strap = 1'b1;
        run = 1'b0;
        cyc(300);
        check(16'({out_a, out_b, fb, lock}), 16'h0000);
        $display("stopped reference done");
        run = 1'b1;
        RSTN = 1'b0;
        cyc(5);
        check(16'({out_a, out_b, fb, lock}), 16'h0000);
        RSTN = 1'b1;
        cyc(LOCK_SIM + 6 * period);
        measure(hi, lo);
        check(hi, half(period));
        check(16'(lock), 16'h0001);
        $display("mid-run reset done");
        wrap_up();
    end
endmodule
